// file: dv/fspi_peer.sv
// far side serial peer: makes the bit clock and sends a frame sync
// assumes the bench resolves the select pin from both enables
module fspi_peer (
    input wire logic run,
    input wire logic drive,
    input wire logic sendSync,
    input wire logic syncHigh,
    output logic linkClk,
    output logic syncDrive,
    output logic syncOen
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    // bit clock stands low while run is low
    initial begin
        linkClk = 1'b0;
        forever #7.5 linkClk = run ? ~linkClk : 1'b0;
    end
    always @(posedge linkClk) begin
        if (sendSync && left == 0) begin
            left <= 8;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign syncDrive = (left > 0) ? syncHigh : ~syncHigh;
    assign syncOen = ~drive;
endmodule : fspi_peer

// file: dv/tb.sv
// self-checking bench for the framed serial port control block
// assumes control word at 0x0, status at 0x4, a peer on the select pin
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    errorCnt++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, xferActive, run, drive, sendSync, syncHigh;
    logic [3:0] awAddr, arAddr, wStrb;
    logic [31:0] wData, rData, d, cfg;
    logic awValid, wValid, bReady, arValid, rReady;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic linkClk, selOut, selOen, peerDrive, peerOen, selPin;
    logic deepMode, edgeUsed;
    int errorCnt = 0;
    int checked = 0;
    int wid, gap;
    logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h0, 3'h6};
    int mult [4] = '{2, 4, 1, 1};
    // released pin has a pull-up
    assign selPin = !selOen ? selOut : (!peerOen ? peerDrive : 1'b1);
    fspi_ctrl DUT (
        .clk(clk), .srst(srst), .linkClk(linkClk),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .xferActive(xferActive), .selectLineIn(selPin),
        .selectLineOut(selOut), .selectLineOen(selOen),
        .deepBufferMode(deepMode), .clockEdgeUsed(edgeUsed)
    );
    fspi_peer peer (
        .run(run), .drive(drive), .sendSync(sendSync),
        .syncHigh(syncHigh), .linkClk(linkClk),
        .syncDrive(peerDrive), .syncOen(peerOen)
    );
    function automatic logic near(input int g, input int e);
        return g >= e - 2 && g <= e + 2;
    endfunction : near
    task automatic stopTest;
        if (errorCnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stopTest
    task automatic wr(input logic [3:0] a, input logic [31:0] v,
            input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            aw = aw && !awReady;
            w = w && !wReady;
            awValid <= aw;
            wValid <= w;
        end
        while (!bValid) @(posedge clk);
        bReady <= 1'b0;
        `CHK("bresp", er, bResp)
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [1:0] er);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        @(posedge clk);
        while (!arReady) @(posedge clk);
        arValid <= 1'b0;
        while (!rValid) @(posedge clk);
        d = rData;
        rReady <= 1'b0;
        `CHK("rresp", er, rResp)
    endtask : rd
    // skip a pulse in progress, then time one whole period
    task automatic pulse(input logic act);
        int t;
        for (t = 0; t < 3000 && selPin === act; t++) @(posedge clk);
        for (t = 0; t < 3000 && selPin !== act; t++) @(posedge clk);
        for (wid = 0; wid < 3000 && selPin === act; wid++) @(posedge clk);
        for (gap = wid; gap < 3000 && selPin !== act; gap++) @(posedge clk);
    endtask : pulse
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #80000;
        errorCnt++;
        stopTest();
    end
    initial begin
        srst = 1'b1;
        {xferActive, run, drive, sendSync, syncHigh} = 5'h00;
        {awAddr, arAddr, wData} = 40'h0;
        wStrb = 4'hF;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("oen", 1'b1, selOen)
        rd(4'h0, 2'h0);
        `CHK("ctrl", 32'h0, d)
        wr(4'h0, 32'hFFFF_FFFF, 2'h0);
        rd(4'h0, 2'h0);
        `CHK("ctrl", 32'hFF03_BFEF, d)
        `CHK("deep", 1'b1, deepMode)
        `CHK("cke", 1'b0, edgeUsed)
        `CHK("oen", 1'b1, selOen)
        wr(4'h0, 32'h0, 2'h0);
        rd(4'h0, 2'h0);
        `CHK("ctrl", 32'h0001_0000, d)
        wr(4'h0, 32'h0000_0100, 2'h0);
        rd(4'h0, 2'h0);
        `CHK("ctrl", 32'h0000_0100, d)
        `CHK("deep", 1'b0, deepMode)
        `CHK("cke", 1'b1, edgeUsed)
        wStrb <= 4'h8;
        wr(4'h0, 32'hFFFF_FFFF, 2'h0);
        wStrb <= 4'hF;
        rd(4'h0, 2'h0);
        `CHK("lanes", 32'hFF00_0100, d)
        wr(4'h8, 32'h0, 2'h2);
        rd(4'h8, 2'h2);
        `CHK("unmapped", 32'h0, d)
        run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, 32'h0, 2'h0);
            cfg = 32'h8000_8020;
            cfg[29] = i[0];
            cfg[27] = (i == 0);
            cfg[26:24] = codes[i];
            cfg[17] = (i == 3);
            wr(4'h0, cfg, 2'h0);
            repeat (4) @(posedge clk);
            `CHK("oen", 1'b0, selOen)
            pulse(i[0]);
            `CHK("width", 1'b1, near(wid, (i == 0) ? 30 : 4))
            `CHK("period", 1'b1, near(gap, 30 * mult[i]))
        end
        wr(4'h0, 32'h0, 2'h0);
        syncHigh <= 1'b1;
        drive <= 1'b1;
        wr(4'h0, 32'hE000_8000, 2'h0);
        `CHK("oen", 1'b1, selOen)
        sendSync <= 1'b1;
        repeat (20) @(posedge clk);
        sendSync <= 1'b0;
        rd(4'h4, 2'h0);
        `CHK("seen", 1'b1, d[0])
        wr(4'h0, 32'h0, 2'h0);
        drive <= 1'b0;
        run <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            cfg = 32'h1000_8020;
            cfg[29] = p[0];
            wr(4'h0, cfg, 2'h0);
            xferActive <= 1'b1;
            repeat (4) @(posedge clk);
            `CHK("selActive", {1'b0, p[0]}, {selOen, selOut})
            xferActive <= 1'b0;
            repeat (4) @(posedge clk);
            `CHK("selIdle", 1'b1, selOen | (selOut ^ p[0]))
        end
        wr(4'h0, 32'h0000_8020, 2'h0);
        xferActive <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("selOff", 1'b1, selOen)
        xferActive <= 1'b0;
        stopTest();
    end
endmodule : tb

// file: hdl/fspi_ctrl.sv
// framed serial port control register and select line driver
// assumes AXI4-Lite on clk, partner serial clock on linkClk
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
module fspi_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic linkClk,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic xferActive,
    input wire logic selectLineIn,
    output logic selectLineOut,
    output logic selectLineOen,
    output logic deepBufferMode,
    output logic clockEdgeUsed
);
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] wmask;
    logic awHave_q, wHave_q, bValid_q, rValid_q;
    logic [3:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic [1:0] bResp_q, rResp_q;
    logic [31:0] rData_q;
    logic doWrite;
    logic [4:0] cfgMeta_q, cfgSync_q;
    logic [3:0] cntMeta_q, cntSync_q;
    logic linkRst;
    logic xferMeta_q, xferSync_q;
    logic selPinMeta_q, selPinSync_q;
    logic syncPulse, syncSeen;
    logic [5:0] charIdx;
    logic [2:0] bitIdx;
    logic [1:0] seenMeta_q;
    logic selOut_q, selOen_q;
    logic isOn, framed, master;
    logic syncIn, polHigh, autoSel;

    assign isOn = ctrl_q[fspi_pkg::ON_BIT];
    assign framed = ctrl_q[fspi_pkg::FRAMED_BIT];
    assign master = ctrl_q[fspi_pkg::MSTEN_BIT];
    assign syncIn = ctrl_q[fspi_pkg::SYNC_DIR_BIT];
    assign polHigh = ctrl_q[fspi_pkg::SYNC_POL_BIT];
    assign autoSel = ctrl_q[fspi_pkg::SEL_AUTO_BIT];

    function automatic logic [31:0] strbMask(input logic [3:0] s);
        strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strbMask

    assign s_axi_awready = !awHave_q && !bValid_q;
    assign s_axi_wready = !wHave_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign doWrite = awHave_q && wHave_q && !bValid_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            awHave_q <= 1'b0;
            awAddr_q <= 4'h0;
        end else if (doWrite) begin
            awHave_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wHave_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (doWrite) begin
            wHave_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bValid_q <= 1'b0;
            bResp_q <= fspi_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q <= (awAddr_q == fspi_pkg::CTRL_ADDR)
                ? fspi_pkg::RESP_OKAY : fspi_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    always_comb begin
        wmask = fspi_pkg::CTRL_WMASK & strbMask(wStrb_q);
        if (isOn) begin
            wmask[fspi_pkg::DEEP_BIT] = 1'b0;
        end
        ctrl_d = (ctrl_q & ~wmask) | (wData_q & wmask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= fspi_pkg::CTRL_RESET;
        end else if (doWrite && awAddr_q == fspi_pkg::CTRL_ADDR) begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rValid_q <= 1'b0;
            rData_q <= 32'h0000_0000;
            rResp_q <= fspi_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rResp_q <= fspi_pkg::RESP_OKAY;
            if (s_axi_araddr == fspi_pkg::CTRL_ADDR) begin
                rData_q <= ctrl_q;
            end else if (s_axi_araddr == fspi_pkg::STAT_ADDR) begin
                rData_q <= {30'h0, selOut_q, seenMeta_q[1]};
            end else begin
                rData_q <= 32'h0000_0000;
                rResp_q <= fspi_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    assign deepBufferMode = ctrl_q[fspi_pkg::DEEP_BIT];
    assign clockEdgeUsed = ctrl_q[fspi_pkg::CKE_BIT] && !framed;

    // config levels cross into the link domain; quasi-static by use
    // per-bit flops only; software must not retune while framed is running
    always_ff @(posedge linkClk) begin
        cfgMeta_q <= {isOn && framed, ctrl_q[fspi_pkg::SYNC_DIR_BIT -: 4]};
        cfgSync_q <= cfgMeta_q;
        cntMeta_q <= {ctrl_q[fspi_pkg::EDGE_BIT], ctrl_q[fspi_pkg::CNT_LSB +: 3]};
        cntSync_q <= cntMeta_q;
        selPinMeta_q <= selectLineIn;
        selPinSync_q <= selPinMeta_q;
    end
    assign linkRst = !cfgSync_q[4];

    fspi_link #(.CHAR_BITS(fspi_pkg::CHAR_BITS)) u_link (
        .linkClk(linkClk),
        .linkRst(linkRst),
        .framedOn(cfgSync_q[4]),
        .syncIsInput(cfgSync_q[3]),
        .syncHigh(cfgSync_q[2]),
        .wideSync(cfgSync_q[0]),
        .earlySync(!cntSync_q[3]),
        .cpsCode(cntSync_q[2:0]),
        .syncPinIn(selPinSync_q),
        .syncPulse(syncPulse),
        .syncSeen(syncSeen),
        .charIdx(charIdx),
        .bitIdx(bitIdx)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            seenMeta_q <= 2'h0;
            xferMeta_q <= 1'b0;
            xferSync_q <= 1'b0;
        end else begin
            seenMeta_q <= {seenMeta_q[0], syncSeen};
            xferMeta_q <= syncPulse;
            xferSync_q <= xferMeta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !isOn) begin
            selOut_q <= 1'b1;
            selOen_q <= 1'b1;
        end else if (framed && !ctrl_q[fspi_pkg::SYNC_DIR_BIT]) begin
            selOen_q <= 1'b0;
            selOut_q <= ctrl_q[fspi_pkg::SYNC_POL_BIT]
                ? xferSync_q : ~xferSync_q;
        end else if (!framed && master
            && ctrl_q[fspi_pkg::SEL_AUTO_BIT]) begin
            selOen_q <= 1'b0;
            selOut_q <= ctrl_q[fspi_pkg::SYNC_POL_BIT]
                ? xferActive : ~xferActive;
        end else begin
            selOen_q <= 1'b1;
            selOut_q <= 1'b1;
        end
    end
    assign selectLineOut = selOut_q;
    assign selectLineOen = selOen_q;

    property p_reserved;
        @(posedge clk) disable iff (srst) ctrl_q[23:18] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved set");
    property p_deeplock;
        @(posedge clk) disable iff (srst)
        $past(isOn) |-> $stable(ctrl_q[fspi_pkg::DEEP_BIT]);
    endproperty
    a_deeplock: assert property (p_deeplock) else $error("deep changed");
    property p_deepout;
        @(posedge clk) disable iff (srst)
        deepBufferMode == ctrl_q[fspi_pkg::DEEP_BIT];
    endproperty
    a_deepout: assert property (p_deepout) else $error("deep out");
    property p_cke;
        @(posedge clk) disable iff (srst) framed |-> !clockEdgeUsed;
    endproperty
    a_cke: assert property (p_cke) else $error("edge used framed");
    property p_slave;
        @(posedge clk) disable iff (srst)
        isOn && framed && syncIn |=> selectLineOen;
    endproperty
    a_slave: assert property (p_slave) else $error("slave drives");
    property p_master;
        @(posedge clk) disable iff (srst)
        isOn && framed && !syncIn |=> !selectLineOen;
    endproperty
    a_master: assert property (p_master) else $error("master idle");
    property p_auto;
        @(posedge clk) disable iff (srst)
        isOn && !framed && master && autoSel && polHigh
        ##0 $stable(ctrl_q) |=> selectLineOut == $past(xferActive);
    endproperty
    a_auto: assert property (p_auto) else $error("auto select");
    property p_pol;
        @(posedge clk) disable iff (srst)
        isOn && framed && !syncIn && !polHigh && $stable(ctrl_q)
        |=> selectLineOut == !$past(xferSync_q);
    endproperty
    a_pol: assert property (p_pol) else $error("sync polarity");
    property p_bresp;
        @(posedge clk) disable iff (srst) doWrite |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("no bresp");

    property p_bdone;
        @(posedge clk) disable iff (srst)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdone: assert property (p_bdone) else $error("bvalid stuck");
    property p_rdone;
        @(posedge clk) disable iff (srst)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdone: assert property (p_rdone) else $error("rvalid stuck");
    property p_aw;
        @(posedge clk) disable iff (srst)
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw: assert property (p_aw) else $error("aw not held");
    property p_rdctrl;
        @(posedge clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == fspi_pkg::CTRL_ADDR
        |=> s_axi_rdata == $past(ctrl_q)
            && s_axi_rresp == fspi_pkg::RESP_OKAY;
    endproperty
    a_rdctrl: assert property (p_rdctrl) else $error("ctrl read");
    property p_unmapped;
        @(posedge clk) disable iff (srst)
        doWrite && awAddr_q != fspi_pkg::CTRL_ADDR
        |=> $stable(ctrl_q)
            && s_axi_bresp == fspi_pkg::RESP_SLVERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write");
    property p_off;
        @(posedge clk) disable iff (srst)
        !isOn |=> selectLineOen && selectLineOut;
    endproperty
    a_off: assert property (p_off) else $error("off drives");
    property p_noauto;
        @(posedge clk) disable iff (srst)
        isOn && !framed && !autoSel |=> selectLineOen;
    endproperty
    a_noauto: assert property (p_noauto) else $error("auto off");
    c_write: cover property (@(posedge clk) doWrite);
    c_framed: cover property (@(posedge clk) isOn && framed);
    c_auto: cover property (@(posedge clk) isOn && autoSel && master);
    c_slave: cover property (@(posedge clk) isOn && framed && syncIn);
    c_reject: cover property (@(posedge clk) doWrite && awAddr_q != 4'h0);
endmodule : fspi_ctrl

// file: hdl/fspi_link.sv
// link side framing engine, runs on the serial bit clock
// assumes its control inputs are already stable in this domain
module fspi_link #(
    parameter int CHAR_BITS = 8
) (
    input wire logic linkClk,
    input wire logic linkRst,
    input wire logic framedOn,
    input wire logic syncIsInput,
    input wire logic syncHigh,
    input wire logic wideSync,
    input wire logic earlySync,
    input wire logic [2:0] cpsCode,
    input wire logic syncPinIn,
    output logic syncPulse,
    output logic syncSeen,
    output logic [5:0] charIdx,
    output logic [2:0] bitIdx
);
    logic [2:0] bit_q;
    logic [5:0] chr_q;
    logic [5:0] period;
    logic sync_q;
    logic seen_q;
    logic inActive;

    always_comb begin
        case (cpsCode)
            3'h0: period = 6'h01;
            3'h1: period = 6'h02;
            3'h2: period = 6'h04;
            3'h3: period = 6'h08;
            3'h4: period = 6'h10;
            3'h5: period = 6'h20;
            default: period = 6'h01;
        endcase
    end

    assign inActive = syncHigh ? syncPinIn : ~syncPinIn;

    always_ff @(posedge linkClk) begin
        if (linkRst || !framedOn) begin
            bit_q <= 3'h0;
            chr_q <= 6'h00;
        end else if (bit_q == 3'(CHAR_BITS - 1)) begin
            bit_q <= 3'h0;
            chr_q <= (chr_q + 6'h01 >= period) ? 6'h00 : chr_q + 6'h01;
        end else begin
            bit_q <= bit_q + 3'h1;
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkRst || !framedOn || syncIsInput) begin
            sync_q <= 1'b0;
        end else if (wideSync) begin
            sync_q <= (chr_q == 6'h00);
        end else if (earlySync) begin
            sync_q <= (bit_q == 3'(CHAR_BITS - 2))
                && (chr_q + 6'h01 >= period);
        end else begin
            sync_q <= (bit_q == 3'(CHAR_BITS - 1))
                && ((chr_q + 6'h01 >= period));
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkRst || !framedOn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= syncIsInput && inActive;
        end
    end

    assign syncPulse = sync_q;
    assign syncSeen = seen_q;
    assign charIdx = chr_q;
    assign bitIdx = bit_q;

    property p_clear;
        @(posedge linkClk) (linkRst || !framedOn) |=> chr_q == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("count kept");
    property p_edge;
        @(posedge linkClk) disable iff (linkRst)
        $rose(sync_q) && !wideSync
        |-> bit_q == (earlySync ? 3'(CHAR_BITS - 1) : 3'h0);
    endproperty
    a_edge: assert property (p_edge) else $error("sync placement");
endmodule : fspi_link

// file: hdl/fspi_pkg.sv
// constants of the framed serial port control block
// assumes an AXI4-Lite master on clk and an external partner on linkClk
// Overview of operation
// - framed enable makes the select line a frame sync input or output
// - direction bit one means sync is input, zero means driven output
// - polarity bit one means active-high sync, zero active-low
// - auto select drives select line during each master transfer
// - width bit picks one character or one bit clock sync pulse
// - count codes 0 to 5 give a sync every 1 to 32 characters
// - edge bit places a one bit clock sync on first bit clock or one before
// - deep buffer bit switches the buffering mode
// - deep buffer bit is writable only while the module is off
// - clock edge bit ignored in framed mode; software writes it zero
// - control bits 23 to 18 read zero and ignore writes
package fspi_pkg;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;
    localparam int FRAMED_BIT = 31;
    localparam int SYNC_DIR_BIT = 30;
    localparam int SYNC_POL_BIT = 29;
    localparam int SEL_AUTO_BIT = 28;
    localparam int SYNC_WIDTH_BIT = 27;
    localparam int CNT_LSB = 24;
    localparam int EDGE_BIT = 17;
    localparam int DEEP_BIT = 16;
    localparam int ON_BIT = 15;
    localparam int CKE_BIT = 8;
    localparam int MSTEN_BIT = 5;
    localparam logic [31:0] CTRL_WMASK = 32'hFF03_BFEF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CHAR_BITS = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fspi_pkg
